// File: rtl/bldc_pkg.sv
package bldc_pkg;

  // APB request bundle, driven by the bus master
  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // Register byte addresses
  localparam logic [7:0] OFF_CAP_CNT = 8'h00;
  localparam logic [7:0] OFF_CAP_CTL = 8'h04;
  localparam logic [7:0] OFF_CAP_STAT = 8'h08;
  localparam logic [7:0] OFF_CAP_IEN = 8'h0C;
  localparam logic [7:0] OFF_IO_CTL0 = 8'h10;
  localparam logic [7:0] OFF_IO_CTL1 = 8'h14;
  localparam logic [7:0] OFF_GEN_A = 8'h18;
  localparam logic [7:0] OFF_CHOP_CNT = 8'h28;
  localparam logic [7:0] OFF_CHOP_CONA = 8'h2C;
  localparam logic [7:0] OFF_CHOP_CONB = 8'h30;
  localparam logic [7:0] OFF_CHOP_CTL0 = 8'h34;
  localparam logic [7:0] OFF_CHOP_STAT = 8'h38;
  localparam logic [7:0] OFF_CHOP_CTL1 = 8'h3C;
  localparam logic [7:0] OFF_PORT_DIR = 8'h40;
  localparam logic [7:0] OFF_PORT_DATA = 8'h44;
  localparam logic [7:0] OFF_STOP_CTL = 8'h48;
  localparam logic [7:0] OFF_STOP_STAT = 8'h4C;
  localparam logic [7:0] GEN_STRIDE = 8'h04;

  // Widths
  localparam int PRESCALER_W = 13;
  localparam int PORT_W = 6;

  // Capture timer control fields
  localparam int CW_CLK_LSB = 0;
  localparam int CW_CLR_A_BIT = 2;
  localparam int CW_RUN_BIT = 7;
  localparam logic [1:0] CW_CLK_DIV2 = 2'h0;
  localparam logic [1:0] CW_CLK_DIV4 = 2'h1;
  localparam logic [1:0] CW_CLK_DIV8 = 2'h2;
  localparam logic [1:0] CW_CLK_EXT = 2'h3;

  // Chop control 0 / control 1 / status fields
  localparam int CV_CKS_LSB = 0;
  localparam int CV_CCLR_LSB = 3;
  localparam int CV_IEN_A_BIT = 6;
  localparam int CV_IEN_B_BIT = 7;
  localparam int CS_OS_A_LSB = 0;
  localparam int CS_OS_B_LSB = 2;
  localparam int CS_FLAG_A_BIT = 6;
  localparam int CS_FLAG_B_BIT = 7;
  localparam int CV1_ICKS_BIT = 0;
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
  localparam logic [1:0] CCLR_NONE = 2'h0;
  localparam logic [1:0] CCLR_MATCH_A = 2'h1;
  localparam logic [1:0] CCLR_MATCH_B = 2'h2;
  localparam logic [1:0] CCLR_EXT = 2'h3;
  localparam logic [1:0] OS_KEEP = 2'h0;
  localparam logic [1:0] OS_LOW = 2'h1;
  localparam logic [1:0] OS_HIGH = 2'h2;

  // Stop input control fields
  localparam int STOP_RISE_BIT = 0;
  localparam int STOP_EN_BIT = 1;

  // Reset values
  localparam logic [15:0] CAP_CNT_RESET = 16'hFFFF;
  localparam logic [15:0] GEN_RESET = 16'hFFFF;
  localparam logic [7:0] CAP_CTL_RESET = 8'h02;
  localparam logic [3:0] IO_FUNC_RESET = 4'hE;
  localparam logic [5:0] IO_EDGE_RESET = 6'h3F;
  localparam logic [7:0] CHOP_CTL0_RESET = 8'h08;
  localparam logic [3:0] CHOP_OS_RESET = 4'h6;
  localparam logic [7:0] CHOP_CON_RESET = 8'hFF;

endpackage

// File: rtl/pin_sync_edge.sv
`timescale 1ns/1ps
module pin_sync_edge
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Asynchronous pin
  input wire logic pinIn,
  // Filtered level and one-cycle edge pulses
  output logic level,
  output logic rise,
  output logic fall
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic [3:0] warmUp;

  // A change counts only when the last two stages agree
  wire settled = (stage2 == stage3) && (stage3 != level);

  // First stage feeds only the second, keeping metastability contained
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      warmUp <= 4'h0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end
    else
    begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      warmUp <= {warmUp[2:0], 1'b1}; // A high pin after reset is no edge
      rise <= settled && stage3 && warmUp[3];
      fall <= settled && !stage3 && warmUp[3];
      if (settled)
        level <= stage3;
    end
  end

endmodule

// File: rtl/bldc_commutation_timers.sv
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
// Contract
// - 13-bit prescaler gives clock over 2 to 8192
// - 16-bit capture counter, clock /2 /4 /8 or external
// - Position edge copies counter, sets channel flag
// - Channel interrupt needs flag and enable both set
// - IO control picks register function and edges
// - Compare A match sets flag, may interrupt
// - Compare A interrupt ends each start step
// - Six fixed-period steps, then sensor commutation
// - Each position interrupt changes phase pattern
// - Capture counter defaults to clock over 8
// - 8-bit chop counter, three-bit plus extra select
// - Chop clear from external, match A or B
// - Chop constants compared, flags and interrupts
// - No chop compare while constant is written
// - Chop counter clears on match A by default
// - Output goes high on A, low on B
// - Chop waveform leaves on its own pin
// - Port bits drive U, /U, V, /V, W, /W
// - Stop input edge raises stop interrupt
// - Direction bit picks latched data or pin
// - External flags clear only by writing 0
module bldc_commutation_timers
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // APB slave
  input wire bldc_pkg::apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Motor side inputs
  input wire logic position_input_b,
  input wire logic position_input_c,
  input wire logic position_input_d,
  input wire logic captureExtClk,
  input wire logic chopExtClk,
  input wire logic chopExtReset,
  input wire logic stop_request_input,
  // Phase port, two-way pins
  input wire logic [5:0] phasePinIn,
  output logic [5:0] phasePinOut,
  output logic [5:0] phasePinOe,
  // Chop waveform and CPU interrupt requests
  output logic chop_output_pin,
  output logic captureTimerIrq,
  output logic chopTimerIrq,
  output logic stopIrq
);

  // Prescaler and divided ticks
  logic [12:0] system_prescaler;
  logic [13:1] tickDiv;
  // Capture timer state
  logic [15:0] capture_timer_counter;
  logic [7:0] capture_timer_control;
  logic [3:0] capture_timer_status;
  logic [3:0] capture_timer_irq_enable;
  logic [3:0] timer_io_control_0;
  logic [5:0] timer_io_control_1;
  logic [15:0] genReg [4];
  logic [3:0] genEq;
  logic [3:0] genEqPrev;
  logic [3:0] genEvent;
  logic [3:0] genWrite;
  logic [3:0] edgeHit;
  // Chop timer state
  logic [7:0] chop_counter;
  logic [7:0] chop_constant_a;
  logic [7:0] chop_constant_b;
  logic [7:0] chop_control_0;
  logic [3:0] chopOutSel;
  logic chop_match_a_flag;
  logic chop_match_b_flag;
  logic chop_control_1;
  logic chopEqA;
  logic chopEqB;
  logic chopEqAPrev;
  logic chopEqBPrev;
  // Port and stop input
  logic [5:0] phase_port_direction;
  logic [5:0] phase_port_data;
  logic [1:0] stopControl;
  logic stopFlag;
  // Synchronised pins
  logic [13:0] pinRaw;
  logic [13:0] pinLevel;
  logic [13:0] pinRise;
  logic [13:0] pinFall;

  // All asynchronous inputs pass the same filtered synchroniser
  assign pinRaw = {phasePinIn, stop_request_input, chopExtReset,
                   chopExtClk, captureExtClk, position_input_d,
                   position_input_c, position_input_b, 1'b0};

  genvar p;
  generate
    for (p = 0; p < 14; p++)
    begin : gSync
      pin_sync_edge uSync
      (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn(pinRaw[p]),
        .level(pinLevel[p]),
        .rise(pinRise[p]),
        .fall(pinFall[p])
      );
    end
  endgenerate

  // Pin map: 1..3 positions, 4 cap clock, 5 chop clock, 6 chop reset,
  // 7 stop, 8..13 phase pins
  wire capExtRise = pinRise[4];
  wire chopExtRise = pinRise[5];
  wire chopExtFall = pinFall[5];
  wire chopResetRise = pinRise[6];
  wire stopEdge = stopControl[bldc_pkg::STOP_RISE_BIT] ? pinRise[7]
                                                       : pinFall[7];
  wire [5:0] phasePinLevel = pinLevel[13:8];

  // APB decode; a write lands only on the edge that completes access
  wire apbAccess = apbReq.psel && apbReq.penable;
  wire wrStrobe = apbAccess && pready && apbReq.pwrite;
  wire [7:0] addr = apbReq.paddr;
  wire [31:0] wdata = apbReq.pwdata;
  wire wrCapCnt = wrStrobe && (addr == bldc_pkg::OFF_CAP_CNT);
  wire wrCapCtl = wrStrobe && (addr == bldc_pkg::OFF_CAP_CTL);
  wire wrCapStat = wrStrobe && (addr == bldc_pkg::OFF_CAP_STAT);
  wire wrCapIen = wrStrobe && (addr == bldc_pkg::OFF_CAP_IEN);
  wire wrIo0 = wrStrobe && (addr == bldc_pkg::OFF_IO_CTL0);
  wire wrIo1 = wrStrobe && (addr == bldc_pkg::OFF_IO_CTL1);
  wire wrChopCnt = wrStrobe && (addr == bldc_pkg::OFF_CHOP_CNT);
  wire wrConA = wrStrobe && (addr == bldc_pkg::OFF_CHOP_CONA);
  wire wrConB = wrStrobe && (addr == bldc_pkg::OFF_CHOP_CONB);
  wire wrChopCtl0 = wrStrobe && (addr == bldc_pkg::OFF_CHOP_CTL0);
  wire wrChopStat = wrStrobe && (addr == bldc_pkg::OFF_CHOP_STAT);
  wire wrChopCtl1 = wrStrobe && (addr == bldc_pkg::OFF_CHOP_CTL1);
  wire wrPortDir = wrStrobe && (addr == bldc_pkg::OFF_PORT_DIR);
  wire wrPortData = wrStrobe && (addr == bldc_pkg::OFF_PORT_DATA);
  wire wrStopCtl = wrStrobe && (addr == bldc_pkg::OFF_STOP_CTL);
  wire wrStopStat = wrStrobe && (addr == bldc_pkg::OFF_STOP_STAT);

  // Prescaler taps: bit k-1 and below all ones means a divide-by-2^k tick
  genvar k;
  generate
    for (k = 1; k <= bldc_pkg::PRESCALER_W; k++)
    begin : gTap
      assign tickDiv[k] = &system_prescaler[k-1:0];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      system_prescaler <= 13'h0000;
    else
      system_prescaler <= system_prescaler + 13'h0001;
  end

  // Capture counter clock select; reset value picks clock over 8
  wire [1:0] capClkSel = capture_timer_control[bldc_pkg::CW_CLK_LSB +: 2];
  wire capClkTick = (capClkSel == bldc_pkg::CW_CLK_DIV2) ? tickDiv[1] :
                    (capClkSel == bldc_pkg::CW_CLK_DIV4) ? tickDiv[2] :
                    (capClkSel == bldc_pkg::CW_CLK_DIV8) ? tickDiv[3] :
                    capExtRise;
  wire capTick = capture_timer_control[bldc_pkg::CW_RUN_BIT] && capClkTick;
  wire capClearA = capture_timer_control[bldc_pkg::CW_CLR_A_BIT]
                   && genEq[0];

  // Counter holds the matched value for one tick, then restarts at zero
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      capture_timer_counter <= bldc_pkg::CAP_CNT_RESET;
    else if (wrCapCnt)
      capture_timer_counter <= wdata[15:0];
    else if (capTick && capClearA)
      capture_timer_counter <= 16'h0000;
    else if (capTick)
      capture_timer_counter <= capture_timer_counter + 16'h0001;
  end

  // Capture control, enables and function select
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      capture_timer_control <= bldc_pkg::CAP_CTL_RESET;
      capture_timer_irq_enable <= 4'h0;
      timer_io_control_0 <= bldc_pkg::IO_FUNC_RESET;
      timer_io_control_1 <= bldc_pkg::IO_EDGE_RESET;
    end
    else
    begin
      if (wrCapCtl)
        capture_timer_control <= wdata[7:0];
      if (wrCapIen)
        capture_timer_irq_enable <= wdata[3:0];
      if (wrIo0)
        timer_io_control_0 <= wdata[3:0];
      if (wrIo1)
        timer_io_control_1 <= wdata[5:0];
    end
  end

  // Channel 0 is compare A; channels 1..3 are capture B, C, D.
  // A capture beats a CPU write landing on the same edge.
  genvar c;
  generate
    for (c = 0; c < 4; c++)
    begin : gChan
      if (c == 0)
      begin : gNoPin
        assign edgeHit[c] = 1'b0;
      end
      else
      begin : gPin
        assign edgeHit[c] = (timer_io_control_1[2*c-2] && pinRise[c])
                         || (timer_io_control_1[2*c-1] && pinFall[c]);
      end
      assign genWrite[c] = wrStrobe
        && (addr == bldc_pkg::OFF_GEN_A + bldc_pkg::GEN_STRIDE * 8'(c));
      assign genEq[c] = (capture_timer_counter == genReg[c]);
      // Capture on selected edge, or compare on a fresh match
      assign genEvent[c] = timer_io_control_0[c]
                           ? edgeHit[c]
                           : (genEq[c] && !genEqPrev[c]);

      always_ff @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
        begin
          genReg[c] <= bldc_pkg::GEN_RESET;
          genEqPrev[c] <= 1'b1; // Equal reset values are no match
          capture_timer_status[c] <= 1'b0;
        end
        else
        begin
          genEqPrev[c] <= genEq[c];
          if (timer_io_control_0[c] && edgeHit[c])
            genReg[c] <= capture_timer_counter;
          else if (genWrite[c])
            genReg[c] <= wdata[15:0];
          // Set beats a same-cycle clear so no event is lost
          if (genEvent[c])
            capture_timer_status[c] <= 1'b1;
          else if (wrCapStat && !wdata[c])
            capture_timer_status[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // Chop counter clock: internal taps over 2..256 or external edges
  wire [2:0] chopCks = chop_control_0[bldc_pkg::CV_CKS_LSB +: 3];
  wire [3:0] chopTapIdx = {chopCks, chop_control_1} - 4'h1;
  logic chopTick;

  always_comb
  begin
    case (chopCks)
      3'h1, 3'h2, 3'h3, 3'h4: chopTick = tickDiv[chopTapIdx];
      bldc_pkg::CKS_EXT_RISE: chopTick = chopExtRise;
      bldc_pkg::CKS_EXT_FALL: chopTick = chopExtFall;
      bldc_pkg::CKS_EXT_BOTH: chopTick = chopExtRise || chopExtFall;
      default: chopTick = 1'b0;
    endcase
  end

  // Compare is blanked on the cycle the constant is being written
  assign chopEqA = (chop_counter == chop_constant_a) && !wrConA;
  assign chopEqB = (chop_counter == chop_constant_b) && !wrConB;
  wire chopMatchA = chopEqA && !chopEqAPrev;
  wire chopMatchB = chopEqB && !chopEqBPrev;
  wire [1:0] chopClr = chop_control_0[bldc_pkg::CV_CCLR_LSB +: 2];
  wire chopClrHit = (chopClr == bldc_pkg::CCLR_MATCH_A && chopEqA)
                 || (chopClr == bldc_pkg::CCLR_MATCH_B && chopEqB);
  wire chopExtClr = (chopClr == bldc_pkg::CCLR_EXT) && chopResetRise;

  // External reset clears at once; match clears on the next count
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      chop_counter <= 8'h00;
    else if (wrChopCnt)
      chop_counter <= wdata[7:0];
    else if (chopExtClr)
      chop_counter <= 8'h00;
    else if (chopTick && chopClrHit)
      chop_counter <= 8'h00;
    else if (chopTick)
      chop_counter <= chop_counter + 8'h01;
  end

  // Chop constants, control and match flags
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chop_constant_a <= bldc_pkg::CHOP_CON_RESET;
      chop_constant_b <= bldc_pkg::CHOP_CON_RESET;
      chop_control_0 <= bldc_pkg::CHOP_CTL0_RESET;
      chop_control_1 <= 1'b0;
      chopOutSel <= bldc_pkg::CHOP_OS_RESET;
      chopEqAPrev <= 1'b0;
      chopEqBPrev <= 1'b0;
      chop_match_a_flag <= 1'b0;
      chop_match_b_flag <= 1'b0;
    end
    else
    begin
      chopEqAPrev <= chopEqA;
      chopEqBPrev <= chopEqB;
      if (wrConA)
        chop_constant_a <= wdata[7:0];
      if (wrConB)
        chop_constant_b <= wdata[7:0];
      if (wrChopCtl0)
        chop_control_0 <= wdata[7:0];
      if (wrChopCtl1)
        chop_control_1 <= wdata[bldc_pkg::CV1_ICKS_BIT];
      if (wrChopStat)
        chopOutSel <= wdata[3:0];
      if (chopMatchA)
        chop_match_a_flag <= 1'b1;
      else if (wrChopStat && !wdata[bldc_pkg::CS_FLAG_A_BIT])
        chop_match_a_flag <= 1'b0;
      if (chopMatchB)
        chop_match_b_flag <= 1'b1;
      else if (wrChopStat && !wdata[bldc_pkg::CS_FLAG_B_BIT])
        chop_match_b_flag <= 1'b0;
    end
  end

  // Output level per match; match B wins when both land together
  wire [1:0] osA = chopOutSel[bldc_pkg::CS_OS_A_LSB +: 2];
  wire [1:0] osB = chopOutSel[bldc_pkg::CS_OS_B_LSB +: 2];
  wire osBAct = chopMatchB && (osB != bldc_pkg::OS_KEEP);
  wire osAAct = chopMatchA && (osA != bldc_pkg::OS_KEEP);
  wire [1:0] osNow = osBAct ? osB : osA;
  wire next_chopOut = (osNow == bldc_pkg::OS_LOW) ? 1'b0 :
                      (osNow == bldc_pkg::OS_HIGH) ? 1'b1 :
                      !chop_output_pin;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      chop_output_pin <= 1'b0;
    else if (osBAct || osAAct)
      chop_output_pin <= next_chopOut;
  end

  // Phase port and stop input; pins drive straight from the latches
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_port_direction <= 6'h00;
      phase_port_data <= 6'h00;
      stopControl <= 2'h0;
      stopFlag <= 1'b0;
    end
    else
    begin
      if (wrPortDir)
        phase_port_direction <= wdata[5:0];
      if (wrPortData)
        phase_port_data <= wdata[5:0];
      if (wrStopCtl)
        stopControl <= wdata[1:0];
      // Flag survives acceptance; only a written 0 clears it
      if (stopEdge)
        stopFlag <= 1'b1;
      else if (wrStopStat && !wdata[0])
        stopFlag <= 1'b0;
    end
  end

  assign phasePinOut = phase_port_data;
  assign phasePinOe = phase_port_direction;

  // Read mux; unmapped addresses read zero with an error
  wire [5:0] portRead = (phase_port_direction & phase_port_data)
                     | (~phase_port_direction & phasePinLevel);
  wire [7:0] chopStatRead = {chop_match_b_flag, chop_match_a_flag,
                             2'h0, chopOutSel};
  logic [31:0] readMux;
  logic readHit;

  always_comb
  begin
    readHit = 1'b1;
    case (addr)
      bldc_pkg::OFF_CAP_CNT: readMux = {16'h0000, capture_timer_counter};
      bldc_pkg::OFF_CAP_CTL: readMux = {24'h00_0000, capture_timer_control};
      bldc_pkg::OFF_CAP_STAT: readMux = {28'h000_0000, capture_timer_status};
      bldc_pkg::OFF_CAP_IEN:
        readMux = {28'h000_0000, capture_timer_irq_enable};
      bldc_pkg::OFF_IO_CTL0: readMux = {28'h000_0000, timer_io_control_0};
      bldc_pkg::OFF_IO_CTL1: readMux = {26'h000_0000, timer_io_control_1};
      8'h18: readMux = {16'h0000, genReg[0]};
      8'h1C: readMux = {16'h0000, genReg[1]};
      8'h20: readMux = {16'h0000, genReg[2]};
      8'h24: readMux = {16'h0000, genReg[3]};
      bldc_pkg::OFF_CHOP_CNT: readMux = {24'h00_0000, chop_counter};
      bldc_pkg::OFF_CHOP_CONA: readMux = {24'h00_0000, chop_constant_a};
      bldc_pkg::OFF_CHOP_CONB: readMux = {24'h00_0000, chop_constant_b};
      bldc_pkg::OFF_CHOP_CTL0: readMux = {24'h00_0000, chop_control_0};
      bldc_pkg::OFF_CHOP_STAT: readMux = {24'h00_0000, chopStatRead};
      bldc_pkg::OFF_CHOP_CTL1: readMux = {31'h0000_0000, chop_control_1};
      bldc_pkg::OFF_PORT_DIR: readMux = {26'h000_0000, phase_port_direction};
      bldc_pkg::OFF_PORT_DATA: readMux = {26'h000_0000, portRead};
      bldc_pkg::OFF_STOP_CTL: readMux = {30'h0000_0000, stopControl};
      bldc_pkg::OFF_STOP_STAT: readMux = {31'h0000_0000, stopFlag};
      default:
      begin
        readMux = 32'h0000_0000;
        readHit = 1'b0;
      end
    endcase
  end

  // One wait state: pready rises on the second access cycle
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= apbAccess && !pready;
      pslverr <= apbAccess && !pready && !readHit; // Stands with pready only
      if (apbAccess && !pready)
        prdata <= apbReq.pwrite ? 32'h0000_0000 : readMux;
    end
  end

  // Interrupt requests need both flag and enable
  wire chopIen = (chop_match_a_flag
                  && chop_control_0[bldc_pkg::CV_IEN_A_BIT])
              || (chop_match_b_flag
                  && chop_control_0[bldc_pkg::CV_IEN_B_BIT]);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      captureTimerIrq <= 1'b0;
      chopTimerIrq <= 1'b0;
      stopIrq <= 1'b0;
    end
    else
    begin
      captureTimerIrq <= |(capture_timer_status
                           & capture_timer_irq_enable);
      chopTimerIrq <= chopIen;
      stopIrq <= stopFlag && stopControl[bldc_pkg::STOP_EN_BIT];
    end
  end

endmodule

// File: testbench/bldc_sva.sv
`timescale 1ns/1ps
module bldc_sva
(
  // Clock, reset and the watched ports
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire bldc_pkg::apb_req_t apbReq,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [5:0] phasePinOut,
  input wire logic [5:0] phasePinOe,
  input wire logic captureTimerIrq,
  input wire logic chopTimerIrq,
  input wire logic stopIrq
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Writes that may lower a level; the irq lags the flag by one edge
  wire logic wrDone = pready && apbReq.pwrite && !pslverr;
  wire logic [7:0] a = apbReq.paddr;
  wire logic clrCap = wrDone && (a == bldc_pkg::OFF_CAP_STAT ||
    a == bldc_pkg::OFF_CAP_IEN);
  wire logic clrChop = wrDone && (a == bldc_pkg::OFF_CHOP_STAT ||
    a == bldc_pkg::OFF_CHOP_CTL0);
  wire logic clrStop = wrDone && (a == bldc_pkg::OFF_STOP_STAT ||
    a == bldc_pkg::OFF_STOP_CTL);
  a_ready_timing: assert property ($rose(apbReq.penable) && apbReq.psel
    |=> pready) else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_error_read_zero: assert property (pslverr && !apbReq.pwrite
    |-> pready && prdata == 32'h0000_0000) else $error("bad error read");
  a_port_data: assert property (wrDone && a == bldc_pkg::OFF_PORT_DATA
    |=> phasePinOut == $past(apbReq.pwdata[5:0])) else $error("port data");
  a_port_dir: assert property (wrDone && a == bldc_pkg::OFF_PORT_DIR
    |=> phasePinOe == $past(apbReq.pwdata[5:0])) else $error("port dir");
  a_capture_held: assert property (captureTimerIrq && !clrCap &&
    !$past(clrCap) |=> captureTimerIrq) else $error("capture irq lost");
  a_chop_held: assert property (chopTimerIrq && !clrChop &&
    !$past(clrChop) |=> chopTimerIrq) else $error("chop irq lost");
  a_stop_held: assert property (stopIrq && !clrStop &&
    !$past(clrStop) |=> stopIrq) else $error("stop irq lost");
endmodule
bind bldc_commutation_timers bldc_sva chk (.clk_sys(clk_sys),
  .rst_b(rst_b), .apbReq(apbReq), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .phasePinOut(phasePinOut), .phasePinOe(phasePinOe),
  .captureTimerIrq(captureTimerIrq), .chopTimerIrq(chopTimerIrq),
  .stopIrq(stopIrq));

// File: testbench/motor_model.sv
`timescale 1ns/1ps
// Driver board and hall sensors; sensors move only on command
module motor_model
(
  // From the device and the bench
  input wire logic [5:0] phasePinOut,
  input wire logic [5:0] phasePinOe,
  input wire logic [5:0] boardLevel,
  input wire logic [2:0] hallIdx,
  input wire logic stopCmd,
  // Towards the device
  output logic hallB,
  output logic hallC,
  output logic hallD,
  output logic stopLine,
  output logic [5:0] phasePinIn
);
  // Hall codes 1,3,2,6,4,5: one line flips per step, both edge kinds
  assign {hallD, hallC, hallB} = 3'(18'h2_CC99 >> (3 * hallIdx));
  assign stopLine = stopCmd;
  // Undriven pins take the board level, which the bench sets once
  assign phasePinIn = (phasePinOut & phasePinOe) | (boardLevel & ~phasePinOe);
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  bldc_pkg::apb_req_t apbReq = '0;
  logic [31:0] prdata, r;
  logic [5:0] pOut, pOe, pIn, board = 6'h00;
  logic pready, pslverr, pb, pc, pd, stopCmd = 1'b0, stopLine, chopPin;
  logic capIrq, chopIrq, stopIrq, e;
  logic [2:0] hallIdx = 3'h0, prev;
  int checks = 0, n_fail = 0, cyc = 0, t0, t1;
  wire logic [3:0] watch = {chopPin, stopIrq, chopIrq, capIrq};
  bldc_commutation_timers uut (.clk_sys(clk_sys), .rst_b(rst_b),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .position_input_b(pb), .position_input_c(pc), .position_input_d(pd),
    .captureExtClk(1'b0), .chopExtClk(1'b0), .chopExtReset(stopCmd),
    .stop_request_input(stopLine), .phasePinIn(pIn), .phasePinOut(pOut),
    .phasePinOe(pOe), .chop_output_pin(chopPin), .captureTimerIrq(capIrq),
    .chopTimerIrq(chopIrq), .stopIrq(stopIrq));
  motor_model motor (.phasePinOut(pOut), .phasePinOe(pOe),
    .boardLevel(board), .hallIdx(hallIdx), .stopCmd(stopCmd), .hallB(pb),
    .hallC(pc), .hallD(pd), .stopLine(stopLine), .phasePinIn(pIn));
  // Clock and a cycle count for period measurements
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  task automatic chk(input string w, input logic [31:0] x, input logic [31:0] y);
    checks++;
    if (y !== x)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", w, x, y);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clk_sys);
    r = prdata;
    e = pslverr;
    apbReq <= '0;
    if (n == 20)
    begin
      chk("bus answer", 32'h0000_0001, 32'h0000_0000);
      summarize();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string w);
    apb(1'b0, a, 32'h0000_0000);
    chk(w, x, r);
  endtask
  // Bounded wait for one watched output to reach a level
  task automatic waitLvl(input int s, input logic v);
    int n;
    for (n = 0; n < 400 && watch[s] !== v; n++)
      @(posedge clk_sys);
    if (n == 400)
    begin
      chk("wait level", 32'(v), 32'(watch[s]));
      summarize();
    end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    rdc(bldc_pkg::OFF_CAP_CNT, 32'h0000_FFFF, "counter");
    rdc(bldc_pkg::OFF_CAP_CTL, 32'h0000_0002, "cap ctl");
    rdc(bldc_pkg::OFF_CHOP_CTL0, 32'h0000_0008, "chop ctl");
    rdc(8'hF0, 32'h0000_0000, "unmapped");
    chk("unmapped err", 32'h0000_0001, 32'(e));
    $display("reset test done");
    apb(1'b1, bldc_pkg::OFF_PORT_DIR, 32'h0000_003F);
    apb(1'b1, bldc_pkg::OFF_PORT_DATA, 32'h0000_0019);
    @(negedge clk_sys);
    chk("phase pins", 32'h0000_0019, 32'(pOut));
    rdc(bldc_pkg::OFF_PORT_DATA, 32'h0000_0019, "latched");
    board <= 6'h26;
    apb(1'b1, bldc_pkg::OFF_PORT_DIR, 32'h0000_0000);
    repeat (6) @(posedge clk_sys);
    rdc(bldc_pkg::OFF_PORT_DATA, 32'h0000_0026, "pin level");
    $display("port test done");
    apb(1'b1, bldc_pkg::OFF_CAP_IEN, 32'h0000_000E);
    apb(1'b1, bldc_pkg::OFF_CAP_CTL, 32'h0000_0082);
    for (int i = 1; i < 7; i++)
    begin
      prev = {pd, pc, pb};
      hallIdx <= 3'(i % 6);
      waitLvl(0, 1'b1);
      rdc(bldc_pkg::OFF_CAP_STAT, 32'({prev ^ {pd, pc, pb}, 1'b0}),
        "edge flag");
      apb(1'b1, bldc_pkg::OFF_CAP_STAT, 32'h0000_0000);
      waitLvl(0, 1'b0);
    end
    apb(1'b1, bldc_pkg::OFF_CAP_IEN, 32'h0000_0000);
    hallIdx <= 3'h1;
    repeat (10) @(posedge clk_sys);
    chk("masked irq", 32'h0000_0000, 32'(capIrq));
    $display("capture test done");
    apb(1'b1, bldc_pkg::OFF_CAP_CTL, 32'h0000_0002);
    apb(1'b1, bldc_pkg::OFF_GEN_A, 32'h0000_0014);
    apb(1'b1, bldc_pkg::OFF_CAP_CNT, 32'h0000_0000);
    apb(1'b1, bldc_pkg::OFF_CAP_STAT, 32'h0000_0000);
    apb(1'b1, bldc_pkg::OFF_CAP_IEN, 32'h0000_0001);
    apb(1'b1, bldc_pkg::OFF_CAP_CTL, 32'h0000_0086);
    for (int i = 0; i < 6; i++)
    begin
      waitLvl(0, 1'b1);
      if (i > 0)
        chk("step", 32'h0000_00A8, 32'(cyc - t0));
      t0 = cyc;
      apb(1'b1, bldc_pkg::OFF_CAP_STAT, 32'h0000_0000);
      apb(1'b1, bldc_pkg::OFF_PORT_DATA, 32'(6'h01 << i));
      waitLvl(0, 1'b0);
    end
    $display("start test done");
    apb(1'b1, bldc_pkg::OFF_CHOP_CONA, 32'h0000_0008);
    apb(1'b1, bldc_pkg::OFF_CHOP_CONB, 32'h0000_0002);
    apb(1'b1, bldc_pkg::OFF_CHOP_CTL0, 32'h0000_0049);
    waitLvl(3, 1'b1);
    waitLvl(3, 1'b0);
    t0 = cyc;
    waitLvl(3, 1'b1);
    t1 = cyc;
    waitLvl(3, 1'b0);
    chk("chop low", 32'h0000_000C, 32'(t1 - t0));
    chk("chop high", 32'h0000_0006, 32'(cyc - t1));
    chk("chop irq", 32'h0000_0001, 32'(chopIrq));
    $display("chop test done");
    apb(1'b1, bldc_pkg::OFF_STOP_CTL, 32'h0000_0003);
    apb(1'b1, bldc_pkg::OFF_CHOP_CTL0, 32'h0000_0018);
    stopCmd <= 1'b1;
    waitLvl(2, 1'b1);
    stopCmd <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("stop held", 32'h0000_0001, 32'(stopIrq));
    rdc(bldc_pkg::OFF_CHOP_CNT, 32'h0000_0000, "chop clear");
    apb(1'b1, bldc_pkg::OFF_STOP_STAT, 32'h0000_0000);
    waitLvl(2, 1'b0);
    $display("stop test done");
    summarize();
  end
endmodule
